// *** hw/spi_cmd_pkg.sv ***
// shared constants and types for the spi master command bridge
package spi_cmd_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ       = 50_000_000;
  localparam int BIT_RATE_HZ  = 1_000_000;
  localparam int CS_GUARD_NS  = 20;
  localparam int CLK_PER_NS   = 1_000_000_000 / CLK_HZ;
  // half a serial bit in system clocks, longest time so rounds down
  localparam int HALF_CYC     = CLK_HZ / (2 * BIT_RATE_HZ);
  // chip-select guard, least time so rounds up, never below one
  localparam int CS_GUARD_CYC =
    (CS_GUARD_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  // each guard phase lasts the longer of half a bit and the guard
  localparam int GUARD_CYC    =
    (CS_GUARD_CYC > HALF_CYC) ? CS_GUARD_CYC : HALF_CYC;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int RD_MAX       = 56;
  localparam int WR_MAX       = 128;
  localparam int RESP_BYTES   = 56;
  localparam int HDR_BYTES    = 2;
  localparam int PH_W         = 6;
  localparam int BUF_DEPTH    = 2;
  localparam logic [7:0] RD_MAX_B  = 8'h38;
  localparam logic [7:0] WR_MAX_B  = 8'h80;
  localparam logic [7:0] IDLE_MOSI = 8'h00;

  // ****************************************************************
  // commands
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_READ_SETUP        = 3'h0,  // payload: address, count
    OP_READ_HEADER       = 3'h1,  // returns address, count
    OP_WRITE_PUSH        = 3'h2,  // payload: raw data bytes
    OP_WRITE_QUEUE_EXEC  = 3'h3,  // payload: address, length, data
    OP_READ_RUN          = 3'h4,  // runs the set-up read
    OP_READ_FETCH        = 3'h5   // returns the read buffer
  } cmd_op_e;

  typedef struct packed {
    cmd_op_e    op;
    logic [7:0] data;
    logic       last;
  } cmd_s;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } resp_s;

  localparam int RESP_W = $bits(resp_s);

endpackage

// *** hw/spi_resp_buf.sv ***
// two-entry shift buffer with registered valid, ready and data
`timescale 1ns/10ps
module spi_resp_buf #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,     // system clock
  input  wire logic             reset_n,   // async reset, active low
  input  wire logic             ce,        // clock enable
  input  wire logic             in_valid,  // fill side valid
  output logic                  in_ready,  // fill side ready
  input  wire logic [WIDTH-1:0] in_data,   // fill side word
  output logic                  out_valid, // drain side valid
  input  wire logic             out_ready, // drain side ready
  output logic      [WIDTH-1:0] out_data   // drain side word
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic [CW-1:0]    wpos;
  logic             push;
  logic             pop;

  assign push      = in_valid && !vld_r[DEPTH-1];
  assign pop       = out_ready && vld_r[0];
  assign in_ready  = !vld_r[DEPTH-1];
  assign out_valid = vld_r[0];
  assign out_data  = mem_r[0];

  always_comb begin
    cnt_nxt = cnt_r;
    wpos    = cnt_r;
    if (pop) begin
      wpos = cnt_r - CW'(1);
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************************************
  // entries: head is entry 0, the rest shift down on a pop
  // ****************************************************************
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        mem_r[i] <= '0;
        vld_r[i] <= 1'b0;
      end else if (ce) begin
        vld_r[i] <= (CW'(i) < cnt_nxt);
        if (push && wpos == CW'(i)) begin
          mem_r[i] <= in_data;
        end else if (pop && i < DEPTH - 1) begin
          mem_r[i] <= mem_r[(i < DEPTH - 1) ? i + 1 : i];
        end
      end
    end
  end

endmodule

// *** hw/spi_master_command_bridge.sv ***
// spi master driven by a byte-wide command stream, with read-back stream
`timescale 1ns/10ps

// Operation
// - one chip-select output only
// - serial clock fixed at one megabit per second
// - transfer reads or writes, never both
// - bytes shifted most significant bit first
// - mode 0: clock idles low, rising samples
// - select leads and trails clock by half a bit (25 clocks), at least 20 ns
// - master silent when device booted over spi
// - read returns at most 56 bytes
// - queued writes combine up to 128 bytes
// - whole transaction under one select assertion
// - read setup stores address and count
// - push appends data, no bus activity
// - push-and-execute appends, then sends queue
// - buffer read returns last read data
// - payload padding beyond length not sent
// - write sends address then data, no gap
module spi_master_command_bridge (
  input  wire logic                clock,       // system clock, 50 MHz
  input  wire logic                reset_n,     // async reset, active low
  input  wire logic                ce,          // clock enable
  input  wire logic                spi_booted,  // device booted over spi
  input  wire spi_cmd_pkg::cmd_s   cmd,         // command byte
  input  wire logic                cmd_valid,   // command byte valid
  output logic                     cmd_ready,   // command byte taken
  output spi_cmd_pkg::resp_s       resp,        // response byte
  output logic                     resp_valid,  // response byte valid
  input  wire logic                resp_ready,  // response byte taken
  output logic                     spi_clk,     // serial clock
  output logic                     spi_cs_n,    // chip select, low active
  output logic                     spi_mosi,    // master-out data
  output logic                     spi_oe,      // drive enable, pins
  input  wire logic                spi_miso,    // master-in data
  output logic                     busy         // transfer in progress
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LEAD = 5'b00010,
    ST_HIGH = 5'b00100,
    ST_LOW  = 5'b01000,
    ST_TAIL = 5'b10000
  } xfer_state_e;

  xfer_state_e state_r;
  logic [1:0]  miso_sync_r;
  logic [1:0]  boot_sync_r;
  logic        miso_s;
  logic        boot_s;
  localparam int PW  = spi_cmd_pkg::PH_W - 1;
  localparam int PHW = spi_cmd_pkg::PH_W;

  logic [PW:0] phase_r;
  logic [2:0]  bit_r;
  logic [7:0]  byte_r;
  logic [7:0]  shift_r;
  logic        is_read_r;
  logic        clk_r;
  logic        cs_n_r;
  logic        mosi_r;
  logic        oe_r;
  logic        cmd_ready_r;
  logic        busy_r;

  logic [7:0]  idx_r;
  logic [7:0]  rd_addr_r;
  logic [7:0]  rd_cnt_r;
  logic [7:0]  wr_addr_r;
  logic [7:0]  wr_len_r;
  logic [7:0]  wq_len_r;
  logic [7:0]  wq_r [spi_cmd_pkg::WR_MAX];
  logic [7:0]  rbuf_r [spi_cmd_pkg::RD_MAX];

  logic        resp_act_r;
  logic        resp_hdr_r;
  logic [7:0]  resp_idx_r;

  logic        acc;
  logic        start_rd;
  logic        start_wr;
  logic        start_resp;
  logic        xfer_done;
  logic        phase_end;
  logic        last_byte;
  logic        rx_byte_done;
  logic [7:0]  rx_byte;
  logic [7:0]  resp_byte;
  logic        resp_last;
  logic        fifo_ready;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      miso_sync_r <= 2'h0;
      boot_sync_r <= 2'h0;
    end else if (ce) begin
      miso_sync_r <= {miso_sync_r[0], spi_miso};
      boot_sync_r <= {boot_sync_r[0], spi_booted};
    end
  end

  assign miso_s = miso_sync_r[1];
  assign boot_s = boot_sync_r[1];

  // ****************************************************************
  // command decode
  // ****************************************************************
  function automatic logic [7:0] clamp(input logic [7:0] v,
                                       input logic [7:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  assign acc        = ce && cmd_valid && cmd_ready_r;
  assign start_rd   = acc && cmd.last && !boot_s &&
                      cmd.op == spi_cmd_pkg::OP_READ_RUN;
  assign start_wr   = acc && cmd.last && !boot_s &&
                      cmd.op == spi_cmd_pkg::OP_WRITE_QUEUE_EXEC;
  assign start_resp = acc && cmd.last &&
                      (cmd.op == spi_cmd_pkg::OP_READ_FETCH ||
                       cmd.op == spi_cmd_pkg::OP_READ_HEADER);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idx_r     <= 8'h00;
      rd_addr_r <= 8'h00;
      rd_cnt_r  <= 8'h00;
      wr_addr_r <= 8'h00;
      wr_len_r  <= 8'h00;
      wq_len_r  <= 8'h00;
    end else if (ce) begin
      if (xfer_done && !is_read_r) begin
        wq_len_r <= 8'h00;
      end
      if (acc) begin
        idx_r <= cmd.last ? 8'h00 : idx_r + 8'h01;
        unique case (cmd.op)
          spi_cmd_pkg::OP_READ_SETUP: begin
            if (idx_r == 8'h00) begin
              rd_addr_r <= cmd.data;
            end
            if (idx_r == 8'h01) begin
              rd_cnt_r <= clamp(cmd.data, spi_cmd_pkg::RD_MAX_B);
            end
          end
          spi_cmd_pkg::OP_WRITE_PUSH,
          spi_cmd_pkg::OP_WRITE_QUEUE_EXEC: begin
            if (cmd.op == spi_cmd_pkg::OP_WRITE_QUEUE_EXEC &&
                idx_r == 8'h00) begin
              wr_addr_r <= cmd.data;
            end else if (cmd.op == spi_cmd_pkg::OP_WRITE_QUEUE_EXEC &&
                         idx_r == 8'h01) begin
              wr_len_r <= clamp(cmd.data, spi_cmd_pkg::WR_MAX_B);
            end else if (wq_len_r < spi_cmd_pkg::WR_MAX_B) begin
              wq_len_r <= wq_len_r + 8'h01;
            end
            // queue dropped when the execute cannot run
            if (cmd.op == spi_cmd_pkg::OP_WRITE_QUEUE_EXEC &&
                cmd.last && boot_s) begin
              wq_len_r <= 8'h00;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // queue storage, written at the fill index only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < spi_cmd_pkg::WR_MAX; i++) begin
        wq_r[i] <= 8'h00;
      end
    end else if (ce && acc && wq_len_r < spi_cmd_pkg::WR_MAX_B &&
                 (cmd.op == spi_cmd_pkg::OP_WRITE_PUSH ||
                  (cmd.op == spi_cmd_pkg::OP_WRITE_QUEUE_EXEC &&
                   idx_r > 8'h01))) begin
      wq_r[wq_len_r[6:0]] <= cmd.data;
    end
  end

  // ****************************************************************
  // transfer engine
  // ****************************************************************
  assign phase_end = (phase_r == PHW'(spi_cmd_pkg::HALF_CYC - 1));
  assign last_byte = byte_r == (is_read_r ? rd_cnt_r : wr_len_r);
  assign rx_byte   = {shift_r[6:0], miso_s};
  assign rx_byte_done = ce && state_r != ST_HIGH && phase_end &&
                        (state_r == ST_LEAD || state_r == ST_LOW) &&
                        bit_r == 3'h0 && is_read_r && byte_r != 8'h00;
  assign xfer_done = state_r == ST_TAIL &&
                     phase_r == PHW'(spi_cmd_pkg::GUARD_CYC - 1);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= ST_IDLE;
      phase_r   <= '0;
      bit_r     <= 3'h7;
      byte_r    <= 8'h00;
      shift_r   <= 8'h00;
      is_read_r <= 1'b0;
      clk_r     <= 1'b0;
      cs_n_r    <= 1'b1;
      busy_r    <= 1'b0;
      mosi_r    <= 1'b0;
    end else if (ce) begin
      phase_r <= phase_end ? '0 : phase_r + PHW'(1);
      unique case (state_r)
        ST_IDLE: begin
          phase_r <= '0;
          clk_r   <= 1'b0;
          cs_n_r  <= 1'b1;
          busy_r  <= 1'b0;
          if (start_rd || start_wr) begin
            state_r   <= ST_LEAD;
            is_read_r <= start_rd;
            cs_n_r    <= 1'b0;
            busy_r    <= 1'b1;
            bit_r     <= 3'h7;
            byte_r    <= 8'h00;
            shift_r   <= start_rd ? rd_addr_r : wr_addr_r;
            mosi_r    <= start_rd ? rd_addr_r[7] : wr_addr_r[7];
          end
        end
        ST_LEAD, ST_LOW: begin
          if (phase_r == PHW'(spi_cmd_pkg::GUARD_CYC - 1) ||
              (state_r == ST_LOW && phase_end)) begin
            phase_r <= '0;
            state_r <= ST_HIGH;
            clk_r   <= 1'b1;
            shift_r <= rx_byte;
            bit_r   <= bit_r - 3'h1;
          end
        end
        ST_HIGH: begin
          if (phase_end) begin
            clk_r <= 1'b0;
            if (bit_r == 3'h7 && last_byte) begin
              state_r <= ST_TAIL;
            end else if (bit_r == 3'h7) begin
              state_r <= ST_LOW;
              byte_r  <= byte_r + 8'h01;
              // next byte follows with no gap under the same select
              shift_r <= is_read_r ? spi_cmd_pkg::IDLE_MOSI
                                   : wq_r[byte_r[6:0]];
              mosi_r  <= is_read_r ? 1'b0 : wq_r[byte_r[6:0]][7];
            end else begin
              state_r <= ST_LOW;
              mosi_r  <= shift_r[7];
            end
          end
        end
        ST_TAIL: begin
          if (xfer_done) begin
            state_r <= ST_IDLE;
            cs_n_r  <= 1'b1;
            busy_r  <= 1'b0;
            phase_r <= '0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // received bytes land behind the address byte
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < spi_cmd_pkg::RD_MAX; i++) begin
        rbuf_r[i] <= 8'h00;
      end
    end else if (rx_byte_done) begin
      rbuf_r[6'(byte_r - 8'h01)] <= rx_byte;
    end
  end

  // pins are released while the device was booted over spi
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      oe_r <= 1'b0;
    end else if (ce) begin
      oe_r <= !boot_s;
    end
  end

  // ****************************************************************
  // responses
  // ****************************************************************
  assign resp_byte = resp_hdr_r ? (resp_idx_r == 8'h00 ? rd_addr_r
                                                       : rd_cnt_r)
                                : rbuf_r[resp_idx_r[5:0]];
  assign resp_last = resp_idx_r == (resp_hdr_r
                       ? 8'(spi_cmd_pkg::HDR_BYTES - 1)
                       : 8'(spi_cmd_pkg::RESP_BYTES - 1));

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      resp_act_r <= 1'b0;
      resp_hdr_r <= 1'b0;
      resp_idx_r <= 8'h00;
    end else if (ce) begin
      if (start_resp) begin
        resp_act_r <= 1'b1;
        resp_hdr_r <= cmd.op == spi_cmd_pkg::OP_READ_HEADER;
        resp_idx_r <= 8'h00;
      end else if (resp_act_r && fifo_ready) begin
        resp_idx_r <= resp_idx_r + 8'h01;
        resp_act_r <= !resp_last;
      end
    end
  end

  // one command at a time; ready drops while a command is serviced
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ready_r <= 1'b0;
    end else if (ce) begin
      cmd_ready_r <= !(start_rd || start_wr || start_resp) &&
                     state_r == ST_IDLE && !resp_act_r;
    end
  end

  spi_resp_buf #(
    .WIDTH (spi_cmd_pkg::RESP_W),
    .DEPTH (spi_cmd_pkg::BUF_DEPTH)
  ) u_resp_buf (
    .clock     (clock),
    .reset_n   (reset_n),
    .ce        (ce),
    .in_valid  (resp_act_r),
    .in_ready  (fifo_ready),
    .in_data   ({resp_byte, resp_last}),
    .out_valid (resp_valid),
    .out_ready (resp_ready),
    .out_data  (resp)
  );

  assign cmd_ready = cmd_ready_r;
  assign spi_clk   = clk_r;
  assign spi_cs_n  = cs_n_r;
  assign spi_mosi  = mosi_r;
  assign spi_oe    = oe_r;
  assign busy      = busy_r;

endmodule

// *** verification/spi_bridge_sva.sv ***
// port checks for the spi master command bridge
`timescale 1ns/10ps
module spi_bridge_sva (
  input wire logic               clock,      // system clock
  input wire logic               reset_n,    // async reset
  input wire logic               ce,         // clock enable
  input wire logic               spi_booted, // booted over spi
  input wire logic               cmd_ready,  // command taken
  input wire spi_cmd_pkg::resp_s resp,       // response byte
  input wire logic               resp_valid, // response valid
  input wire logic               resp_ready, // response taken
  input wire logic               spi_clk,    // serial clock
  input wire logic               spi_cs_n,   // chip select
  input wire logic               spi_mosi,   // master-out
  input wire logic               spi_oe,     // pin enable
  input wire logic               busy        // transfer running
);
  // ****************************************************************
  // level run length of the serial clock
  // ****************************************************************
  logic       clk_r;
  logic [7:0] run_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clk_r <= 1'b0;
      run_r <= 8'h00;
    end else begin
      clk_r <= spi_clk;
      if (spi_clk != clk_r) run_r <= 8'h00;
      else if (run_r != 8'hff) run_r <= run_r + 8'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_clk_idle_low: assert property (spi_cs_n |-> !spi_clk)
    else $error("serial clock high outside a frame");
  a_half_bit: assert property ((clk_r && !spi_clk) |-> run_r == 8'h18)
    else $error("serial clock high phase not 25 cycles");
  a_cs_lead: assert property (
    $fell(spi_cs_n) |-> (!spi_clk)[*8] ##18 $rose(spi_clk))
    else $error("select lead time wrong");
  a_cs_trail: assert property (
    $rose(spi_cs_n) |-> !$past(spi_clk) && run_r == 8'h18)
    else $error("select trail time wrong");
  a_booted_quiet: assert property (spi_booted[*4] |-> !spi_oe)
    else $error("pins driven while booted over spi");
  a_busy_frame: assert property (busy == !spi_cs_n)
    else $error("busy differs from select");
  a_cmd_blocked: assert property (!spi_cs_n |-> !cmd_ready)
    else $error("command accepted during a frame");
  a_mosi_fall: assert property (
    !spi_cs_n && $changed(spi_mosi) |-> $fell(spi_clk) || $fell(spi_cs_n))
    else $error("master-out changed away from a falling clock");
  a_resp_hold: assert property (
    resp_valid && !resp_ready && ce |=> resp_valid && $stable(resp))
    else $error("response lost while stalled");
endmodule

bind spi_master_command_bridge spi_bridge_sva i_spi_bridge_sva (
  .clock, .reset_n, .ce, .spi_booted, .cmd_ready, .resp, .resp_valid,
  .resp_ready, .spi_clk, .spi_cs_n, .spi_mosi, .spi_oe, .busy);

// *** verification/spi_dev_model.sv ***
// behavioural spi peripheral with a readable register array
`timescale 1ns/10ps
module spi_dev_model (
  input  wire logic spi_clk,  // serial clock
  input  wire logic spi_cs_n, // select, low active
  input  wire logic spi_mosi, // data from master
  output logic      spi_miso  // data to master
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] addr;
  int         nbit;
  logic [7:0] rx_q [$];

  initial begin
    spi_miso = 1'b0;
    nbit = 0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end

  // released line shows the inverse, never the last bit
  always @(posedge spi_cs_n) spi_miso = ~spi_miso;
  always @(negedge spi_cs_n) nbit = 0;

  always @(posedge spi_clk) begin
    if (!spi_cs_n) begin
      sh = {sh[6:0], spi_mosi};
      nbit++;
      if (nbit % 8 == 0) rx_q.push_back(sh);
      if (nbit == 8) addr = sh;
    end
  end

  always @(negedge spi_clk) begin
    if (!spi_cs_n && nbit < 8) spi_miso = ~spi_miso;
    else if (!spi_cs_n) spi_miso = mem[8'(addr + (nbit - 8) / 8)][7 - nbit % 8];
  end
endmodule

// *** verification/test_spi_master_command_bridge.sv ***
// self-checking bench for the spi master command bridge
`timescale 1ns/10ps
module test_spi_master_command_bridge;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] c;
    logic [7:0] x;
  } row_s;
  // address, requested count, count actually read
  localparam row_s ROWS [4] = '{'{8'h06, 8'h01, 8'h01},
    '{8'h64, 8'h10, 8'h10}, '{8'hf0, 8'h00, 8'h00}, '{8'h10, 8'h3c, 8'h38}};

  logic               clock, reset_n, ce, spi_booted, cmd_valid, cmd_ready;
  spi_cmd_pkg::cmd_s  cmd;
  spi_cmd_pkg::resp_s resp;
  logic               resp_valid, resp_ready, spi_clk, spi_cs_n, spi_mosi;
  logic               spi_oe, spi_miso, busy, l;
  logic [7:0]         b;
  int                 failures, n_checks;

  spi_master_command_bridge i_spi_master_command_bridge (.clock, .reset_n,
    .ce, .spi_booted, .cmd, .cmd_valid, .cmd_ready, .resp, .resp_valid,
    .resp_ready, .spi_clk, .spi_cs_n, .spi_mosi, .spi_oe, .spi_miso, .busy);
  spi_dev_model i_spi_dev_model (.spi_clk, .spi_cs_n, .spi_mosi, .spi_miso);

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic hang;
    failures++;
    wrap_up();
  endtask

  task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(logic got, logic exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered and left at a falling edge; valid stays up between bytes
  task automatic send(spi_cmd_pkg::cmd_op_e op, logic [7:0] d, logic t);
    int n;
    cmd.op = op;
    cmd.data = d;
    cmd.last = t;
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      n++;
      if (n > 60000) hang();
      @(negedge clock);
    end
    @(negedge clock);
  endtask

  task automatic get(output logic [7:0] d, output logic t);
    int n;
    n = 0;
    while (resp_valid !== 1'b1) begin
      n++;
      if (n > 100) hang();
      @(negedge clock);
    end
    d = resp.data;
    t = resp.last;
    @(negedge clock);
  endtask

  task automatic xfer;
    int n;
    n = 0;
    while (spi_cs_n !== 1'b0) begin
      n++;
      if (n > 100) hang();
      @(negedge clock);
    end
    n = 0;
    while (spi_cs_n !== 1'b1) begin
      n++;
      if (n > 60000) hang();
      @(negedge clock);
    end
  endtask

  // ****************************************************************
  // stimulus
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    spi_booted = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    resp_ready = 1'b1;
    failures = 0;
    n_checks = 0;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    chk_bit(spi_oe, 1'b1);
    for (int r = 0; r < 4; r++) begin
      i_spi_dev_model.rx_q.delete();
      send(spi_cmd_pkg::OP_READ_SETUP, ROWS[r].a, 1'b0);
      send(spi_cmd_pkg::OP_READ_SETUP, ROWS[r].c, 1'b1);
      send(spi_cmd_pkg::OP_READ_RUN, 8'h00, 1'b1);
      cmd_valid = 1'b0;
      xfer();
      b = 8'(i_spi_dev_model.rx_q.size());
      chk_byte(b, ROWS[r].x + 8'h01);
      chk_byte(i_spi_dev_model.rx_q[0], ROWS[r].a);
      for (int i = 1; i <= ROWS[r].x; i++)
        chk_byte(i_spi_dev_model.rx_q[i], 8'h00);
      send(spi_cmd_pkg::OP_READ_FETCH, 8'h00, 1'b1);
      cmd_valid = 1'b0;
      for (int i = 0; i < 56; i++) begin
        if (i % 9 == 4) begin
          resp_ready = 1'b0;
          repeat (4) @(negedge clock);
          resp_ready = 1'b1;
        end
        get(b, l);
        if (i < ROWS[r].x) chk_byte(b, 8'(ROWS[r].a + i) ^ 8'h5a);
        chk_bit(l, i == 55);
      end
    end
    // header after a clamped count, receiver stalled first
    send(spi_cmd_pkg::OP_READ_HEADER, 8'h00, 1'b1);
    cmd_valid = 1'b0;
    resp_ready = 1'b0;
    repeat (8) @(negedge clock);
    resp_ready = 1'b1;
    get(b, l);
    chk_byte(b, 8'h10);
    get(b, l);
    chk_byte(b, 8'h38);
    chk_bit(l, 1'b1);
    // 56 pushed bytes, then address, length 70, 14 bytes and padding
    i_spi_dev_model.rx_q.delete();
    for (int i = 0; i < 56; i++)
      send(spi_cmd_pkg::OP_WRITE_PUSH, 8'(i), i == 55);
    cmd_valid = 1'b0;
    repeat (60) @(negedge clock);
    chk_bit(spi_cs_n, 1'b1);
    for (int i = 0; i < 56; i++)
      send(spi_cmd_pkg::OP_WRITE_QUEUE_EXEC, i == 0 ? 8'h64 : i == 1 ? 8'h46 :
        i < 16 ? 8'(i + 54) : 8'hee, i == 55);
    cmd_valid = 1'b0;
    xfer();
    chk_byte(8'(i_spi_dev_model.rx_q.size()), 8'h47);
    chk_byte(i_spi_dev_model.rx_q[0], 8'h64);
    for (int i = 1; i < 71; i++)
      chk_byte(i_spi_dev_model.rx_q[i], 8'(i - 1));
    // booted over spi: no pin drive, run refused
    spi_booted = 1'b1;
    repeat (6) @(negedge clock);
    chk_bit(spi_oe, 1'b0);
    send(spi_cmd_pkg::OP_READ_RUN, 8'h00, 1'b1);
    cmd_valid = 1'b0;
    l = 1'b0;
    repeat (200) begin
      @(negedge clock);
      if (spi_cs_n !== 1'b1) l = 1'b1;
    end
    chk_bit(l, 1'b0);
    spi_booted = 1'b0;
    repeat (6) @(negedge clock);
    // reset in mid-frame returns to idle
    send(spi_cmd_pkg::OP_READ_RUN, 8'h00, 1'b1);
    cmd_valid = 1'b0;
    repeat (300) @(negedge clock);
    chk_bit(busy, 1'b1);
    reset_n = 1'b0;
    @(negedge clock);
    chk_bit(spi_cs_n, 1'b1);
    chk_bit(spi_clk, 1'b0);
    chk_bit(cmd_ready, 1'b0);
    chk_bit(resp_valid, 1'b0);
    reset_n = 1'b1;
    repeat (5) @(negedge clock);
    chk_bit(cmd_ready, 1'b1);
    wrap_up();
  end
endmodule
